//--- src/boost_mode_pkg.sv
package boost_mode_pkg;

  // ==========================================================
  // register access
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int PHASES = 4;

  localparam logic [ADDR_W-1:0] ADDR_MODE_CONTROL  = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_GATE_ENABLE   = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_PHASE_TO_RAIL = 6'h02;
  localparam logic [ADDR_W-1:0] ADDR_LOGIC1_VPHASE = 6'h0B;
  localparam logic [ADDR_W-1:0] ADDR_LOGIC2_VPHASE = 6'h0C;
  localparam logic [ADDR_W-1:0] ADDR_DIAG_STATUS   = 6'h20;

  // ==========================================================
  // mode control fields
  localparam int FIRST_RAIL_BIT   = 0;
  localparam int SECOND_RAIL_BIT  = 1;
  localparam int GATE_SUPPLY_BIT  = 2;
  localparam int SETUP_DONE_BIT   = 7;

  // ==========================================================
  // diagnostic status fields
  localparam int DIAG_MODE_LSB    = 0;
  localparam int DIAG_GSG_BIT     = 5;
  localparam int DIAG_EVER_BIT    = 6;

  // ==========================================================
  // reset values
  localparam logic [PHASES-1:0] PHASE_FIELD_RESET = 4'h0;
  localparam logic [DATA_W-1:0] RDATA_RESET       = 8'h00;

  // ==========================================================
  // operating modes
  typedef enum logic [4:0] {
    MODE_OFF         = 5'h01,
    MODE_CONFIG      = 5'h02,
    MODE_OPERATION   = 5'h04,
    MODE_FAIL_SILENT = 5'h08,
    MODE_CALIBRATION = 5'h10
  } mode_type;

endpackage : boost_mode_pkg

//--- src/boost_mode_and_phase_config.sv
// Notes on behaviour
// - low supply or low enable pin forces off mode
// - off mode: register port and all outputs disabled
// - supply good and enable high: off goes straight to configuration
// - configuration: control and configuration read/write, diagnostics read only
// - configuration: gate supply off until a rail was enabled, rails off
// - writing setup-complete to one moves configuration to operation, or to calibration with gate supply on and rails off
// - setup-complete set: configuration registers locked except in calibration, control stays writable
// - operation: either rail switch starts the gate-drive supply
// - rail turned on only once gate supply is good
// - battery monitoring only while converters run
// - overtemperature or gate-driver fault: operation to fail-silent
// - supply under- or overvoltage also enters fail-silent
// - fail-silent: outputs and gate supply off, port works, enable restarts
// - clearing setup-complete reopens configuration write access
// - up to four internal phases over two virtual outputs
// - logic 1 virtual phase enables in bits 3..0
// - logic 2 virtual phase enables, same layout
// - phase-to-rail map bits 3..0, zero rail 1, one rail 2
// - gate enable register bits 3..0 switch physical phases
module boost_mode_and_phase_config (
  // clock and reset
  input  wire logic                                 i_clk,
  input  wire logic                                 i_rst_n,
  // supply and pin monitors
  input  wire logic                                 i_power_on_ok,
  input  wire logic                                 i_enable_pin,
  input  wire logic                                 i_undervoltage,
  input  wire logic                                 i_overvoltage,
  input  wire logic                                 i_overtemp,
  input  wire logic                                 i_gate_fault,
  input  wire logic                                 i_gate_supply_good,
  // register access
  input  wire logic                                 i_wr_en,
  input  wire logic                                 i_rd_en,
  input  wire logic [boost_mode_pkg::ADDR_W-1:0]    i_addr,
  input  wire logic [boost_mode_pkg::DATA_W-1:0]    i_wdata,
  output logic      [boost_mode_pkg::DATA_W-1:0]    o_rdata,
  output logic                                      o_rdata_valid,
  output logic                                      o_port_active,
  // supply and rail control
  output logic                                      o_gate_drive_supply_on,
  output logic                                      o_first_output_rail_on,
  output logic                                      o_second_output_rail_on,
  output logic                                      o_battery_monitor_on,
  output logic                                      o_calibrate,
  output logic      [4:0]                           o_mode,
  // phase control
  output logic      [boost_mode_pkg::PHASES-1:0]    o_phase_gate_on,
  output logic      [boost_mode_pkg::PHASES-1:0]    o_phase_rail_sel,
  output logic      [boost_mode_pkg::PHASES-1:0]    o_logic1_vphase_on,
  output logic      [boost_mode_pkg::PHASES-1:0]    o_logic2_vphase_on
);
  import boost_mode_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    mode_type          mode;
    logic              first_rail_switch;
    logic              second_rail_switch;
    logic              gate_supply_req;
    logic              setup_complete_flag;
    logic              rail_ever_enabled;
    logic [PHASES-1:0] gate_enable;
    logic [PHASES-1:0] phase_to_rail_map;
    logic [PHASES-1:0] logic1_vphase;
    logic [PHASES-1:0] logic2_vphase;
    logic [DATA_W-1:0] rdata;
    logic              rdata_valid;
  } state_type;

  localparam state_type STATE_RESET = '{
    mode:                MODE_OFF,
    first_rail_switch:   1'b0,
    second_rail_switch:  1'b0,
    gate_supply_req:     1'b0,
    setup_complete_flag: 1'b0,
    rail_ever_enabled:   1'b0,
    gate_enable:         PHASE_FIELD_RESET,
    phase_to_rail_map:   PHASE_FIELD_RESET,
    logic1_vphase:       PHASE_FIELD_RESET,
    logic2_vphase:       PHASE_FIELD_RESET,
    rdata:               RDATA_RESET,
    rdata_valid:         1'b0
  };

  state_type state;
  state_type next_state;

  logic supply_fault;
  logic run_fault;
  logic port_on;
  logic cfg_open;
  logic rail_write_on;
  logic gate_on;
  logic rail1_on;
  logic rail2_on;
  logic              supply_up;
  logic              ctl_write;
  logic              cfg_write;
  logic              rd_take;
  logic [DATA_W-1:0] control_word;
  logic [DATA_W-1:0] diag_word;

  // ==========================================================
  // combinational helpers
  assign supply_fault = i_undervoltage | i_overvoltage;
  assign run_fault    = i_overtemp | i_gate_fault;
  assign port_on      = (state.mode != MODE_OFF);
  // configuration registers writable while setup not done, or in calibration
  assign cfg_open     = !state.setup_complete_flag || (state.mode == MODE_CALIBRATION);
  assign rail_write_on = ctl_write && (i_addr == ADDR_MODE_CONTROL)
                         && (i_wdata[FIRST_RAIL_BIT] || i_wdata[SECOND_RAIL_BIT]);

  // ==========================================================
  // register port
  assign supply_up = i_power_on_ok && i_enable_pin;
  assign ctl_write = i_wr_en && port_on;
  assign cfg_write = ctl_write && cfg_open;
  assign rd_take   = i_rd_en && port_on;
  // read-back images of the control and diagnostic registers
  assign control_word = {state.setup_complete_flag, 4'h0, state.gate_supply_req,
                         state.second_rail_switch, state.first_rail_switch};
  assign diag_word    = {1'b0, state.rail_ever_enabled, i_gate_supply_good, state.mode};

  // ==========================================================
  // gate supply and rails
  always_comb begin
    gate_on = 1'b0;
    case (state.mode)
      MODE_CONFIG: begin
        // request only counts once a rail was enabled
        gate_on = state.rail_ever_enabled && state.gate_supply_req;
      end
      MODE_OPERATION: begin
        gate_on = state.gate_supply_req || state.first_rail_switch
                  || state.second_rail_switch;
      end
      MODE_CALIBRATION: begin
        gate_on = state.gate_supply_req;
      end
      MODE_OFF: begin
        gate_on = 1'b0;
      end
      MODE_FAIL_SILENT: begin
        gate_on = 1'b0;
      end
      default: begin
        gate_on = 1'b0;
      end
    endcase
  end

  assign rail1_on = (state.mode == MODE_OPERATION) && state.first_rail_switch
                    && i_gate_supply_good;
  assign rail2_on = (state.mode == MODE_OPERATION) && state.second_rail_switch
                    && i_gate_supply_good;

  // ==========================================================
  // next state
  always_comb begin
    next_state             = state;
    next_state.rdata_valid = 1'b0;

    // register writes
    if (ctl_write) begin
      if (i_addr == ADDR_MODE_CONTROL) begin
        next_state.first_rail_switch   = i_wdata[FIRST_RAIL_BIT];
        next_state.second_rail_switch  = i_wdata[SECOND_RAIL_BIT];
        next_state.gate_supply_req     = i_wdata[GATE_SUPPLY_BIT];
        next_state.setup_complete_flag = i_wdata[SETUP_DONE_BIT];
      end else if (i_addr == ADDR_GATE_ENABLE) begin
        if (cfg_write) begin
          next_state.gate_enable = i_wdata[PHASES-1:0];
        end
      end else if (i_addr == ADDR_PHASE_TO_RAIL) begin
        if (cfg_write) begin
          next_state.phase_to_rail_map = i_wdata[PHASES-1:0];
        end
      end else if (i_addr == ADDR_LOGIC1_VPHASE) begin
        if (cfg_write) begin
          next_state.logic1_vphase = i_wdata[PHASES-1:0];
        end
      end else if (i_addr == ADDR_LOGIC2_VPHASE) begin
        if (cfg_write) begin
          next_state.logic2_vphase = i_wdata[PHASES-1:0];
        end
      end
    end

    if (rail_write_on) begin
      next_state.rail_ever_enabled = 1'b1;
    end

    // register reads, diagnostics read only
    if (rd_take) begin
      next_state.rdata_valid = 1'b1;
      if (i_addr == ADDR_MODE_CONTROL) begin
        next_state.rdata = control_word;
      end else if (i_addr == ADDR_GATE_ENABLE) begin
        next_state.rdata = {4'h0, state.gate_enable};
      end else if (i_addr == ADDR_PHASE_TO_RAIL) begin
        next_state.rdata = {4'h0, state.phase_to_rail_map};
      end else if (i_addr == ADDR_LOGIC1_VPHASE) begin
        next_state.rdata = {4'h0, state.logic1_vphase};
      end else if (i_addr == ADDR_LOGIC2_VPHASE) begin
        next_state.rdata = {4'h0, state.logic2_vphase};
      end else if (i_addr == ADDR_DIAG_STATUS) begin
        next_state.rdata = diag_word;
      end else begin
        // unmapped addresses read as zero
        next_state.rdata = RDATA_RESET;
      end
    end

    // mode sequencing
    case (state.mode)
      MODE_OFF: begin
        if (supply_up) begin
          next_state.mode = MODE_CONFIG;
        end
      end
      MODE_CONFIG: begin
        if (supply_fault) begin
          next_state.mode = MODE_FAIL_SILENT;
        end else if (next_state.setup_complete_flag && !state.setup_complete_flag) begin
          // supply on and rails off at the rising edge starts calibration
          if (state.gate_supply_req && state.rail_ever_enabled
              && !next_state.first_rail_switch && !next_state.second_rail_switch) begin
            next_state.mode = MODE_CALIBRATION;
          end else begin
            next_state.mode = MODE_OPERATION;
          end
        end
      end
      MODE_OPERATION: begin
        if (run_fault || supply_fault) begin
          next_state.mode = MODE_FAIL_SILENT;
        end else if (!next_state.setup_complete_flag) begin
          next_state.mode = MODE_CONFIG;
        end
      end
      MODE_CALIBRATION: begin
        if (supply_fault || run_fault) begin
          next_state.mode = MODE_FAIL_SILENT;
        end else if (!next_state.setup_complete_flag) begin
          next_state.mode = MODE_CONFIG;
        end
      end
      MODE_FAIL_SILENT: begin
        next_state.mode = MODE_FAIL_SILENT;
      end
      default: begin
        next_state.mode = MODE_OFF;
      end
    endcase

    // off has top priority and clears everything
    if (!supply_up) begin
      next_state = STATE_RESET;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // outputs
  assign o_rdata                 = state.rdata;
  assign o_rdata_valid           = state.rdata_valid;
  assign o_port_active           = port_on;
  assign o_gate_drive_supply_on  = gate_on;
  assign o_first_output_rail_on  = rail1_on;
  assign o_second_output_rail_on = rail2_on;
  assign o_battery_monitor_on    = rail1_on || rail2_on;
  assign o_calibrate             = (state.mode == MODE_CALIBRATION);
  assign o_mode                  = state.mode;

  // ==========================================================
  // phase outputs, gate and virtual-phase enables active only in operation, rail select always follows the map
  for (genvar p = 0; p < PHASES; p++) begin : g_phase
    logic mapped_rail_on;
    // a physical phase follows whichever rail the map ties it to
    assign mapped_rail_on        = state.phase_to_rail_map[p] ? rail2_on : rail1_on;
    assign o_phase_gate_on[p]    = mapped_rail_on && state.gate_enable[p];
    assign o_phase_rail_sel[p]   = state.phase_to_rail_map[p];
    assign o_logic1_vphase_on[p] = rail1_on && state.logic1_vphase[p];
    assign o_logic2_vphase_on[p] = rail2_on && state.logic2_vphase[p];
  end

endmodule : boost_mode_and_phase_config

//--- verification/boost_mode_checker.sv
module boost_mode_checker
  import boost_mode_pkg::*;
(
  // clock, reset and monitors
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_power_on_ok,
  input wire logic       i_enable_pin,
  input wire logic       i_undervoltage,
  input wire logic       i_overvoltage,
  input wire logic       i_overtemp,
  input wire logic       i_gate_fault,
  input wire logic       i_gate_supply_good,
  input wire logic       i_rd_en,
  // watched outputs
  input wire logic       o_rdata_valid,
  input wire logic       o_port_active,
  input wire logic       o_gate_drive_supply_on,
  input wire logic       o_first_output_rail_on,
  input wire logic       o_second_output_rail_on,
  input wire logic       o_battery_monitor_on,
  input wire logic [4:0] o_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic up;
  logic rails;
  assign up = i_power_on_ok & i_enable_pin;
  assign rails = o_first_output_rail_on | o_second_output_rail_on;
  // ==========================================================
  // mode sequencing
  off_entry_a: assert property (!up |=> o_mode == MODE_OFF)
    else $error("off mode not entered");
  off_quiet_a: assert property (o_mode == MODE_OFF |->
    !o_port_active && !o_gate_drive_supply_on && !rails) else $error("off mode not quiet");
  cfg_entry_a: assert property (o_mode == MODE_OFF && up |=> o_mode == MODE_CONFIG)
    else $error("config not entered");
  read_answer_a: assert property (i_rd_en && o_port_active && up |=> o_rdata_valid)
    else $error("read not answered");
  cfg_rails_a: assert property (o_mode == MODE_CONFIG |-> !rails)
    else $error("rail on in config");
  rail_good_a: assert property (rails |-> i_gate_supply_good)
    else $error("rail on without good supply");
  battery_mon_a: assert property (o_battery_monitor_on == rails)
    else $error("battery monitor wrong");
  run_fault_a: assert property (o_mode == MODE_OPERATION && up &&
    (i_overtemp || i_gate_fault) |=> o_mode == MODE_FAIL_SILENT) else $error("run fault missed");
  supply_fault_a: assert property (o_mode == MODE_OPERATION && up &&
    (i_undervoltage || i_overvoltage) |=> o_mode == MODE_FAIL_SILENT) else $error("supply fault");
  silent_out_a: assert property (o_mode == MODE_FAIL_SILENT |->
    o_port_active && !o_gate_drive_supply_on && !rails) else $error("fail-silent outputs");
  mode_code_a: assert property ($onehot(o_mode))
    else $error("mode not one-hot");
  cover property (o_mode == MODE_OPERATION);
  cover property (o_mode == MODE_CALIBRATION);
  cover property (o_mode == MODE_FAIL_SILENT);
endmodule : boost_mode_checker

bind boost_mode_and_phase_config boost_mode_checker chk (.*);

//--- verification/gate_supply_model.sv
module gate_supply_model #(
  parameter int DELAY = 4
) (
  input  wire logic i_clk,
  input  wire logic i_supply_on,
  output logic      o_good
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // regulator settles some cycles after enable, drops at the next clock edge when off
  always @(posedge i_clk) begin
    if (!i_supply_on) cnt <= 0;
    else if (cnt < DELAY) cnt <= cnt + 1;
  end
  assign o_good = (cnt == DELAY);
endmodule : gate_supply_model

//--- verification/boost_mode_and_phase_config_test.sv
module boost_mode_and_phase_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  import boost_mode_pkg::*;
  `define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
  logic clk = 0, rst_n = 0, pwr = 0, en = 0, gsg, wr = 0, rd = 0;
  logic [3:0] flt = 0;
  logic [ADDR_W-1:0] addr = 0;
  logic [DATA_W-1:0] wd = 0, rdata;
  logic rv, act, gs, r1, r2, bat, cal;
  logic [4:0] mode;
  logic [3:0] pg, ps, v1, v2;
  int fail_count = 0, check_count = 0;
  always #2 clk = ~clk;
  boost_mode_and_phase_config uut (
    .i_clk(clk), .i_rst_n(rst_n), .i_power_on_ok(pwr), .i_enable_pin(en),
    .i_undervoltage(flt[2]), .i_overvoltage(flt[3]), .i_overtemp(flt[0]),
    .i_gate_fault(flt[1]), .i_gate_supply_good(gsg), .i_wr_en(wr), .i_rd_en(rd),
    .i_addr(addr), .i_wdata(wd), .o_rdata(rdata), .o_rdata_valid(rv), .o_port_active(act),
    .o_gate_drive_supply_on(gs), .o_first_output_rail_on(r1), .o_second_output_rail_on(r2),
    .o_battery_monitor_on(bat), .o_calibrate(cal), .o_mode(mode), .o_phase_gate_on(pg),
    .o_phase_rail_sel(ps), .o_logic1_vphase_on(v1), .o_logic2_vphase_on(v2));
  gate_supply_model gsm (.i_clk(clk), .i_supply_on(gs), .o_good(gsg));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic wrr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wrr
  task automatic rdc(input logic [5:0] a, input logic [7:0] e, input logic v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("valid", v, rv)
    if (v) `CHK("rdata", e, rdata)
  endtask : rdc
  task end_of_test;
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    step(1);
    `CHK("mode", 5'h01, mode)
    rdc(ADDR_DIAG_STATUS, 8'h00, 1'b0);
    @(posedge clk);
    pwr <= 1'b1;
    en <= 1'b1;
    step(1);
    `CHK("mode", 5'h02, mode)
    wrr(ADDR_LOGIC1_VPHASE, 8'h05);
    wrr(ADDR_LOGIC2_VPHASE, 8'h0A);
    wrr(ADDR_PHASE_TO_RAIL, 8'h03);
    wrr(ADDR_GATE_ENABLE, 8'h0F);
    wrr(ADDR_DIAG_STATUS, 8'hFF);
    rdc(ADDR_LOGIC1_VPHASE, 8'h05, 1'b1);
    rdc(ADDR_LOGIC2_VPHASE, 8'h0A, 1'b1);
    rdc(ADDR_PHASE_TO_RAIL, 8'h03, 1'b1);
    rdc(ADDR_GATE_ENABLE, 8'h0F, 1'b1);
    rdc(ADDR_DIAG_STATUS, 8'h02, 1'b1);
    wrr(ADDR_MODE_CONTROL, 8'h01);
    `CHK("gate", 1'b0, gs)
    wrr(ADDR_MODE_CONTROL, 8'h05);
    `CHK("gate", 1'b1, gs)
    wrr(ADDR_MODE_CONTROL, 8'h84);
    `CHK("calib", 1'b1, cal)
    wrr(ADDR_MODE_CONTROL, 8'h04);
    `CHK("mode", 5'h02, mode)
    wrr(ADDR_MODE_CONTROL, 8'h81);
    `CHK("mode", 5'h04, mode)
    step(6);
    `CHK("rail1", 1'b1, r1)
    `CHK("battery", 1'b1, bat)
    `CHK("phase gate", 4'hC, pg)
    `CHK("rail sel", 4'h3, ps)
    `CHK("logic1", 4'h5, v1)
    `CHK("logic2", 4'h0, v2)
    wrr(ADDR_LOGIC1_VPHASE, 8'h0F);
    rdc(ADDR_LOGIC1_VPHASE, 8'h05, 1'b1);
    wrr(ADDR_MODE_CONTROL, 8'h83);
    `CHK("logic2", 4'hA, v2)
    `CHK("phase gate", 4'hF, pg)
    wrr(ADDR_MODE_CONTROL, 8'h03);
    `CHK("mode", 5'h02, mode)
    wrr(ADDR_LOGIC1_VPHASE, 8'h0F);
    rdc(ADDR_LOGIC1_VPHASE, 8'h0F, 1'b1);
    // one pass per fault source, restart by cycling enable
    for (int i = 0; i < 4; i++) begin
      wrr(ADDR_MODE_CONTROL, 8'h80);
      `CHK("gate", 1'b0, gs)
      wrr(ADDR_MODE_CONTROL, 8'h82);
      `CHK("gate", 1'b1, gs)
      step(6);
      `CHK("rail2", 1'b1, r2)
      @(posedge clk);
      flt <= 4'h1 << i;
      step(1);
      `CHK("mode", 5'h08, mode)
      `CHK("outputs", 4'h8, {act, gs, r1, r2})
      @(posedge clk);
      en <= 1'b0;
      flt <= 4'h0;
      step(1);
      `CHK("mode", 5'h01, mode)
      @(posedge clk);
      en <= 1'b1;
      step(1);
      `CHK("mode", 5'h02, mode)
    end
    end_of_test();
  end
endmodule : boost_mode_and_phase_config_test
